// >>> src/relay_spi_pkg.sv
// register map, frame layout and reset values of the relay driver serial status bank
package relay_spi_pkg;
  localparam int          CHANNELS         = 8;
  localparam int          CNT_W            = 6;
  localparam logic [1:0]  OP_WRITE         = 2'b10;
  localparam logic [1:0]  OP_READ          = 2'b01;
  localparam logic [1:0]  TAIL_REG_READ    = 2'b10;
  localparam logic [1:0]  TAIL_STAT_READ   = 2'b01;
  localparam logic [1:0]  READ_REPLY_TAG   = 2'b10;
  localparam logic [5:0]  ADDR_OUTPUT      = 6'h00;
  localparam logic [5:0]  ADDR_INRUSH      = 6'h01;
  localparam logic [5:0]  ADDR_PIN0_ROUTE  = 6'h04;
  localparam logic [5:0]  ADDR_INPUT_STAT  = 6'h06;
  localparam int          OP_HI            = 15;
  localparam int          OP_LO            = 14;
  localparam int          ADDR_HI          = 13;
  localparam int          ADDR_LO          = 8;
  localparam int          DATA_HI          = 7;
  localparam logic [CNT_W-1:0] LEN_SHORT   = 6'd16;
  localparam logic [CNT_W-1:0] LEN_MID     = 6'd24;
  localparam logic [CNT_W-1:0] LEN_LONG    = 6'd32;
  localparam logic [CNT_W-1:0] CNT_MAX     = 6'h3F;
  localparam logic [CNT_W-1:0] WORD_BITS   = 6'd16;
  localparam logic [15:0] STATUS_RESET     = 16'h7800;
  localparam logic [15:0] TX_RESET_REPLY   = 16'h8680;
  localparam logic [15:0] SYNTAX_ERR_REPLY = 16'hFFFF;
  localparam logic [7:0]  OUTPUT_RESET     = 8'h00;
  localparam logic [7:0]  INRUSH_RESET     = 8'h00;
  localparam logic [7:0]  PIN0_ROUTE_RESET = 8'h04;
  localparam logic [1:0]  MODE_RESET       = 2'b11;
  localparam int          SYNC_W           = 38;
  localparam logic [SYNC_W-1:0] SYNC_RESET = {1'b1, 1'b1, MODE_RESET, 34'h0_0000_0000};
endpackage : relay_spi_pkg

// >>> src/spi_frame_if.sv
// frame words passed between the serial link logic and the register bank
interface spi_frame_if;
  logic [15:0] rx_word;
  logic [5:0]  bit_count;
  logic        no_clocks;
  logic [15:0] tx_word;
  modport link (output rx_word, output bit_count, output no_clocks, input tx_word);
  modport bank (input rx_word, input bit_count, input no_clocks, output tx_word);
endinterface : spi_frame_if

// >>> src/spi_frame_link.sv
// serial clock domain: shifts the command in and the prepared reply out
module spi_frame_link
  import relay_spi_pkg::*;
(
  input  wire logic  i_sclk,
  input  wire logic  i_csn,
  input  wire logic  i_si,
  output logic       o_so,
  output logic       o_so_oen,
  spi_frame_if.link  lnk
);
  logic [15:0]      rx_sr;
  logic [CNT_W-1:0] count_reg;
  logic             fresh_reg;
  logic [CNT_W-1:0] bit_idx;
  logic [3:0]       tx_sel;
  logic             idle_frame_reg;

  // no sclk edge follows the frame, so the frame start is marked by the select line
  // itself; the count survives the deselect for the bank to pick up
  always_ff @(negedge i_sclk or posedge i_csn)
  begin
    if (i_csn)
      fresh_reg <= 1'b1;
    else
      fresh_reg <= 1'b0;
  end

  // the pending mark is raised by the very edge that ends a frame, so whether the frame
  // saw any clock at all is kept from the value the mark had just before that edge
  always_ff @(posedge i_csn)
  begin
    idle_frame_reg <= fresh_reg;
  end

  always_ff @(negedge i_sclk)
  begin
    rx_sr <= {rx_sr[14:0], i_si};
    if (fresh_reg)
      count_reg <= 6'd1;
    else if (count_reg != CNT_MAX)
      count_reg <= count_reg + 6'd1;
  end

  assign bit_idx  = fresh_reg ? 6'd0 : count_reg;
  assign tx_sel   = 4'(15 - int'(bit_idx[3:0]));
  // reply word is held steady by the bank for the whole frame
  // past 16 clocks the received stream is passed on for daisy chaining
  assign o_so     = (bit_idx < WORD_BITS) ? lnk.tx_word[tx_sel] : rx_sr[15];
  assign o_so_oen = i_csn;

  assign lnk.rx_word   = rx_sr;
  assign lnk.bit_count = count_reg;
  assign lnk.no_clocks = idle_frame_reg;
endmodule : spi_frame_link

// >>> src/relay_driver_spi_status_regs.sv
// register bank and status word of the eight channel relay driver serial port
module relay_driver_spi_status_regs
  import relay_spi_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_rstn,
  input  wire logic                i_sclk,
  input  wire logic                i_csn,
  input  wire logic                i_si,
  output logic                     o_so,
  output logic                     o_so_oen,
  input  wire logic                i_supply_uv,
  input  wire logic                i_vdd_low,
  input  wire logic [1:0]          i_mode,
  input  wire logic [1:0]          i_in_pins,
  input  wire logic [CHANNELS-1:0] i_open_load_on,
  input  wire logic [CHANNELS-1:0] i_open_load_off,
  input  wire logic [CHANNELS-1:0] i_channel_fault,
  input  wire logic [CHANNELS-1:0] i_diag_current_enable,
  output logic [CHANNELS-1:0]      o_output_on,
  output logic [CHANNELS-1:0]      o_inrush_mode,
  output logic [CHANNELS-1:0]      o_input_pin0_route
);
  spi_frame_if lnk ();

  spi_frame_link u_link (
    .i_sclk   (i_sclk),
    .i_csn    (i_csn),
    .i_si     (i_si),
    .o_so     (o_so),
    .o_so_oen (o_so_oen),
    .lnk      (lnk.link)
  );

  // ---------------- pin synchronisers ----------------
  logic              csn_meta;
  logic              csn_sync;
  logic              csn_last;
  logic [SYNC_W-1:0] pins_meta;
  logic [SYNC_W-1:0] pins_sync;
  logic [SYNC_W-1:0] pins_raw;

  assign pins_raw = {i_supply_uv, i_vdd_low, i_mode, i_in_pins, i_open_load_on,
                     i_open_load_off, i_channel_fault, i_diag_current_enable};

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      csn_meta  <= 1'b1;
      csn_sync  <= 1'b1;
      csn_last  <= 1'b1;
      pins_meta <= SYNC_RESET;
      pins_sync <= SYNC_RESET;
    end
    else
    begin
      csn_meta  <= i_csn;
      csn_sync  <= csn_meta;
      csn_last  <= csn_sync;
      pins_meta <= pins_raw;
      pins_sync <= pins_meta;
    end
  end

  logic                uv_s;
  logic                vdd_low_s;
  logic [1:0]          mode_s;
  logic [1:0]          in_pins_s;
  logic [CHANNELS-1:0] ol_on_s;
  logic [CHANNELS-1:0] ol_off_s;
  logic [CHANNELS-1:0] fault_s;
  logic [CHANNELS-1:0] diag_en_s;

  assign {uv_s, vdd_low_s, mode_s, in_pins_s, ol_on_s, ol_off_s, fault_s, diag_en_s} = pins_sync;

  // ---------------- frame decode ----------------
  // the link words are quasi static once select is high: no sclk edge can move them
  logic             frame_done;
  logic [15:0]      cmd;
  logic [CNT_W-1:0] eff_count;
  logic             count_ok;
  logic [5:0]       addr;
  logic             is_write;
  logic             is_read;
  logic             is_stat;
  logic             hit_rw;
  logic             hit_ro;
  logic             write_ok;
  logic             read_ok;
  logic             stat_req;
  logic             syntax_err;
  logic             load_status;
  logic [7:0]       wr_data;

  assign frame_done = csn_sync & ~csn_last;
  assign cmd        = lnk.rx_word;
  assign eff_count  = lnk.no_clocks ? 6'd0 : lnk.bit_count;
  assign count_ok   = (eff_count == LEN_SHORT) | (eff_count == LEN_MID) | (eff_count == LEN_LONG);
  assign addr       = cmd[ADDR_HI:ADDR_LO];
  assign wr_data    = cmd[DATA_HI:0];
  assign is_write   = cmd[OP_HI:OP_LO] == OP_WRITE;
  assign is_read    = (cmd[OP_HI:OP_LO] == OP_READ) & (cmd[1:0] == TAIL_REG_READ);
  assign is_stat    = (cmd[OP_HI:OP_LO] == OP_READ) & (cmd[1:0] == TAIL_STAT_READ);
  // pwm control frames carry no secondary field and are not served by this bank
  assign hit_rw     = (addr == ADDR_OUTPUT) | (addr == ADDR_INRUSH) | (addr == ADDR_PIN0_ROUTE);
  assign hit_ro     = addr == ADDR_INPUT_STAT;
  assign write_ok   = count_ok & is_write & hit_rw;
  assign read_ok    = count_ok & is_read & (hit_rw | hit_ro);
  assign stat_req   = count_ok & is_stat;
  assign syntax_err = count_ok & ~(write_ok | read_ok | stat_req);
  assign load_status = frame_done & ~read_ok & ~syntax_err;

  // ---------------- registers ----------------
  logic [7:0] out_reg;
  logic [7:0] out_next;
  logic [7:0] inrush_reg;
  logic [7:0] inrush_next;
  logic [7:0] route_reg;
  logic [7:0] route_next;

  assign out_next    = (frame_done & write_ok & (addr == ADDR_OUTPUT)) ? wr_data : out_reg;
  assign inrush_next = (frame_done & write_ok & (addr == ADDR_INRUSH)) ? wr_data : inrush_reg;
  assign route_next  = (frame_done & write_ok & (addr == ADDR_PIN0_ROUTE)) ? wr_data : route_reg;

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      out_reg    <= OUTPUT_RESET;
      inrush_reg <= INRUSH_RESET;
      route_reg  <= PIN0_ROUTE_RESET;
    end
    else
    begin
      out_reg    <= out_next;
      inrush_reg <= inrush_next;
      route_reg  <= route_next;
    end
  end

  // ---------------- status word ----------------
  logic                uv_reg;
  logic                uv_next;
  logic                lop_reg;
  logic                lop_next;
  logic                ter_reg;
  logic                ter_next;
  logic [CHANNELS-1:0] err_reg;
  logic [CHANNELS-1:0] err_next;
  logic                ol_on_flag;
  logic                ol_off_flag;
  logic [15:0]         status_word;
  logic [15:0]         reply_status;
  logic [7:0]          input_status;

  // sticky flags uv, lop and err: a new event in the readout cycle wins over the clear; ter follows each frame
  assign uv_next  = uv_s | (uv_reg & ~load_status);
  assign lop_next = vdd_low_s | (lop_reg & ~load_status);
  assign ter_next = frame_done ? ~count_ok : ter_reg;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++)
    begin : g_fault
      assign err_next[ch] = fault_s[ch] | (err_reg[ch] & ~load_status);
    end
  endgenerate

  assign ol_on_flag  = |(out_reg & ol_on_s);
  assign ol_off_flag = |(~out_reg & diag_en_s & ol_off_s);
  assign status_word = {1'b0, uv_reg, lop_reg, mode_s, ter_reg, ol_on_flag, ol_off_flag, err_reg};
  // the reply reports the frame that has just ended, so its error bit is taken live
  assign reply_status = {status_word[15:11], ~count_ok, status_word[9:0]};
  assign input_status = {~count_ok, 5'b0_0000, in_pins_s};

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      uv_reg  <= STATUS_RESET[14];
      lop_reg <= STATUS_RESET[13];
      ter_reg <= 1'b1;
      err_reg <= STATUS_RESET[7:0];
    end
    else
    begin
      uv_reg  <= uv_next;
      lop_reg <= lop_next;
      ter_reg <= ter_next;
      err_reg <= err_next;
    end
  end

  // ---------------- reply word ----------------
  logic [7:0]  rd_data;
  logic [15:0] tx_reg;
  logic [15:0] tx_next;

  assign rd_data = (addr == ADDR_OUTPUT)  ? out_reg :
                   (addr == ADDR_INRUSH)  ? inrush_reg :
                   (addr == ADDR_PIN0_ROUTE) ? route_reg : input_status;
  assign tx_next = !frame_done ? tx_reg :
                   !count_ok   ? reply_status :
                   syntax_err  ? SYNTAX_ERR_REPLY :
                   read_ok     ? {READ_REPLY_TAG, addr, rd_data} : reply_status;

  // reset reply is the input status frame with the error bit high
  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      tx_reg <= TX_RESET_REPLY;
    else
      tx_reg <= tx_next;
  end

  assign lnk.tx_word        = tx_reg;
  assign o_output_on        = out_reg;
  assign o_inrush_mode      = inrush_reg;
  assign o_input_pin0_route = route_reg;

  // ---------------- checks ----------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  a_reset_reply_input_status_register: assert property (disable iff (1'b0) !i_rstn |=> tx_reg == TX_RESET_REPLY)
    else $error("reply after reset is not the input status frame");
  a_ter_tracks_len: assert property (frame_done |=> ter_reg == !$past(count_ok))
    else $error("transfer error flag does not follow frame length");
  a_write_output: assert property (frame_done && write_ok && addr == ADDR_OUTPUT |=> out_reg == $past(wr_data))
    else $error("output control write lost");
  a_read_reply_tag: assert property (frame_done && read_ok |=> tx_reg[15:14] == READ_REPLY_TAG && tx_reg[13:8] == $past(addr))
    else $error("read reply lacks tag or address");
  a_syntax_reply: assert property (frame_done && syntax_err |=> tx_reg == SYNTAX_ERR_REPLY)
    else $error("syntax error not answered with error reply");
  a_uv_sticky: assert property (uv_s |=> uv_reg ##1 (uv_reg || $past(load_status)))
    else $error("undervoltage flag dropped without readout");
  a_status_clear: assert property (load_status && !uv_s |=> !uv_reg)
    else $error("status readout did not clear undervoltage flag");
  a_fault_flag: assert property ($rose(fault_s[0]) |=> status_word[0])
    else $error("channel fault not reported");
  a_reply_steady: assert property (!csn_sync && !csn_last |=> $stable(tx_reg))
    else $error("reply word moved during a frame");
  a_status_top_zero: assert property (frame_done && load_status |=> tx_reg[15] == 1'b0)
    else $error("status reply bit 15 not zero");
  a_reset_regs: assert property (disable iff (1'b0) !i_rstn |=>
    out_reg == OUTPUT_RESET && inrush_reg == INRUSH_RESET && route_reg == PIN0_ROUTE_RESET)
    else $error("register reset values wrong");
  a_write_inrush: assert property (frame_done && write_ok && addr == ADDR_INRUSH |=>
    inrush_reg == $past(wr_data))
    else $error("inrush mode write lost");
  a_write_route: assert property (frame_done && write_ok && addr == ADDR_PIN0_ROUTE |=>
    route_reg == $past(wr_data))
    else $error("input pin 0 routing write lost");
  a_lop_sticky: assert property (vdd_low_s |=> lop_reg)
    else $error("logic supply low flag not latched");
  a_lop_clear: assert property (load_status && !vdd_low_s |=> !lop_reg)
    else $error("status readout did not clear logic supply low flag");
  a_mode_reply: assert property (frame_done && load_status |=> tx_reg[12:11] == $past(mode_s))
    else $error("mode code missing from status reply");
  a_open_load_on_flag_clear: assert property (frame_done && load_status && (out_reg & ol_on_s) == 8'h00 |=> !tx_reg[9])
    else $error("open load on flag set with no open load");
  a_open_load_off_flag_ignores_on: assert property (frame_done && load_status && (~out_reg & ol_off_s) == 8'h00 |=>
    !tx_reg[8])
    else $error("open load off flag set by a channel that is on");
  a_bad_len_reply: assert property (frame_done && !count_ok |=> tx_reg[15] == 1'b0 && tx_reg[10])
    else $error("bad length not answered with error status");
  a_bad_len_hold: assert property (frame_done && !count_ok |=>
    $stable(out_reg) && $stable(inrush_reg) && $stable(route_reg))
    else $error("register written by a frame of bad length");
  a_syntax_hold: assert property (frame_done && syntax_err |=>
    $stable(out_reg) && $stable(inrush_reg) && $stable(route_reg))
    else $error("register written by a frame with a syntax error");
  a_reply_idle: assert property (!frame_done |=> $stable(tx_reg))
    else $error("reply word moved without a frame end");
  a_read_data: assert property (frame_done && read_ok && addr == ADDR_OUTPUT |=>
    tx_reg[7:0] == $past(out_reg))
    else $error("read reply carries wrong content");
  a_err_reply: assert property (frame_done && load_status |=> tx_reg[7:0] == $past(err_reg))
    else $error("fault flags missing from status reply");
  a_write_reply: assert property (frame_done && write_ok |=> !tx_reg[15] && !tx_reg[10])
    else $error("write not answered with clean status");

  // per channel: a fault is held until a status reply has been loaded
  genvar fc;
  generate
    for (fc = 0; fc < CHANNELS; fc++)
    begin : g_fault_chk
      a_fault_hold: assert property (err_reg[fc] && !load_status |=> err_reg[fc])
        else $error("channel fault flag dropped without readout");
      a_fault_set: assert property (fault_s[fc] |=> err_reg[fc])
        else $error("channel fault not latched");
    end
  endgenerate

  c_write_frame: cover property (frame_done && write_ok);
  c_read_frame:  cover property (frame_done && read_ok);
  c_bad_length:  cover property (frame_done && !count_ok);
  c_status_read: cover property (frame_done && stat_req && uv_reg);
  c_syntax_frame: cover property (frame_done && syntax_err);
endmodule : relay_driver_spi_status_regs

// >>> tb/spi_host_model.sv
// host side serial master model: frames of any clock count on a 6 ns link clock
module spi_host_model (
  output logic      o_sclk,
  output logic      o_csn,
  output logic      o_si,
  input  wire logic i_so
);
  timeunit 1ns;
  timeprecision 100ps;

  initial
  begin
    o_sclk = 1'b0;
    o_csn  = 1'b0;
    o_si   = 1'b0;
    // the link has no reset: one select edge while the bank is held in reset arms it
    #1 o_csn = 1'b1;
  end

  // clock stands low between frames; data moves while clock is high, away from the sampling fall
  task automatic xfer(input logic [31:0] cmd, input int nbits, output logic [15:0] rep);
    rep = 16'h0000;
    o_csn = 1'b0;
    #3;
    for (int b = nbits - 1; b >= 0; b--)
    begin
      #3 o_sclk = 1'b1;
      if (nbits - 1 - b < 16)
        rep[b - nbits + 16] = i_so;
      #1 o_si = cmd[b];
      #2 o_sclk = 1'b0;
    end
    #3 o_csn = 1'b1;
    // released line shows the inverse so a stale bit is never mistaken for data
    o_si = ~o_si;
    #120;
  endtask : xfer
endmodule : spi_host_model

// >>> tb/relay_driver_spi_status_regs_test.sv
// self-checking bench for the relay driver serial status bank
module relay_driver_spi_status_regs_test
  import relay_spi_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] STAT = 32'h0000_4001;

  logic        clk;
  logic        rstn;
  wire logic   sclk;
  wire logic   csn;
  wire logic   si;
  logic        so;
  logic        so_oen;
  logic        uv;
  logic        vdd_low;
  logic [1:0]  mode;
  logic [1:0]  in_pins;
  logic [7:0]  ol_on;
  logic [7:0]  ol_off;
  logic [7:0]  fault;
  logic [7:0]  diag;
  logic [7:0]  out_on;
  logic [7:0]  inrush;
  logic [7:0]  route;
  logic [15:0] rep;
  int          fail_count;
  int          n_tests;

  relay_driver_spi_status_regs i_relay_driver_spi_status_regs (
    .i_clk(clk), .i_rstn(rstn), .i_sclk(sclk), .i_csn(csn), .i_si(si), .o_so(so), .o_so_oen(so_oen),
    .i_supply_uv(uv), .i_vdd_low(vdd_low), .i_mode(mode), .i_in_pins(in_pins), .i_open_load_on(ol_on),
    .i_open_load_off(ol_off), .i_channel_fault(fault), .i_diag_current_enable(diag),
    .o_output_on(out_on), .o_inrush_mode(inrush), .o_input_pin0_route(route));

  spi_host_model i_spi_host_model (.o_sclk(sclk), .o_csn(csn), .o_si(si), .i_so(so));

  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // the reply checked is the answer to the frame sent before this one
  task automatic fr(input logic [31:0] cmd, input int n, input logic [15:0] exp, input string name);
    i_spi_host_model.xfer(cmd, n, rep);
    chk(name, exp, rep);
  endtask : fr

  task automatic t_reset;
    chk("out and inrush reset", 16'h0000, {out_on, inrush});
    chk("route reset", 16'h0004, {8'h00, route});
    chk("so enable while idle", 16'h0001, {15'h0000, so_oen});
    fork
      fr(STAT, 16, 16'h8680, "first reply");
      begin
        #20;
        chk("so enable while selected", 16'h0000, {15'h0000, so_oen});
      end
    join
    fr(STAT, 16, 16'h7800, "second reply");
    fr(STAT, 16, 16'h1800, "sticky cleared");
  endtask : t_reset

  task automatic t_regs;
    logic [5:0] a[3];
    logic [7:0] d[3];
    logic [7:0] rv[3];
    logic [7:0] port;
    a = '{ADDR_OUTPUT, ADDR_INRUSH, ADDR_PIN0_ROUTE};
    d = '{8'hA5, 8'h5A, 8'h3C};
    rv = '{8'h00, 8'h00, 8'h04};
    for (int i = 0; i < 3; i++)
    begin
      fr({16'h0000, OP_READ, a[i], 6'h00, 2'b10}, 16, 16'h1800, "before read");
      fr({16'h0000, OP_WRITE, a[i], d[i]}, 16, {2'b10, a[i], rv[i]}, "reset value read");
      port = (i == 0) ? out_on : (i == 1) ? inrush : route;
      chk("register port", {8'h00, d[i]}, {8'h00, port});
      fr({16'h0000, OP_READ, a[i], 6'h00, 2'b10}, 16, 16'h1800, "write reply");
      fr(STAT, 16, {2'b10, a[i], d[i]}, "read back");
    end
  endtask : t_regs

  task automatic t_bad;
    fr(32'h0000_0080, 8, 16'h1800, "before short frame");
    fr(32'h0000_8000, 17, 16'h1C00, "after 8 clocks");
    chk("no write on bad count", 16'h00A5, {8'h00, out_on});
    fr(32'h0000_80FF, 24, 16'h1C00, "after 17 clocks");
    chk("write in 24 clocks", 16'h00FF, {8'h00, out_on});
    fr(32'h0000_80A5, 32, 16'h1800, "after 24 clocks");
    fr(STAT, 16, 16'h1800, "after 32 clocks");
    chk("write in 32 clocks", 16'h00A5, {8'h00, out_on});
  endtask : t_bad

  task automatic t_syntax;
    logic [15:0] c[5];
    logic [15:0] e[5];
    c = '{16'hC000, 16'h0002, 16'h4C02, 16'h8C11, 16'h4001};
    e = '{16'h1800, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};
    for (int i = 0; i < 5; i++)
      fr({16'h0000, c[i]}, 16, e[i], "syntax reply");
    chk("no write on syntax error", 16'h00A5, {8'h00, out_on});
  endtask : t_syntax

  task automatic t_sticky;
    @(negedge clk);
    uv = 1'b1;
    vdd_low = 1'b1;
    repeat (5) @(negedge clk);
    uv = 1'b0;
    vdd_low = 1'b0;
    repeat (5) @(negedge clk);
    fr(STAT, 16, 16'h1800, "before supply event");
    fr(STAT, 16, 16'h7800, "supply events held");
    fr(STAT, 16, 16'h1800, "cleared by readout");
  endtask : t_sticky

  task automatic t_input;
    @(negedge clk);
    in_pins = 2'b10;
    repeat (5) @(negedge clk);
    fr({16'h0000, OP_READ, ADDR_INPUT_STAT, 6'h00, 2'b10}, 16, 16'h1800, "before input read");
    fr(STAT, 16, {READ_REPLY_TAG, ADDR_INPUT_STAT, 8'h02}, "input status read");
  endtask : t_input

  task automatic t_status;
    logic [39:0] v[3];
    logic [15:0] e[3];
    logic [7:0]  md;
    // mode, fault, open load on, open load off, diag enable; channel 0 is on, channel 1 off
    v = '{40'h01_8101_0000, 40'h02_4200_0202, 40'h03_0000_0301};
    e = '{16'h0A81, 16'h1142, 16'h1800};
    for (int i = 0; i < 3; i++)
    begin
      @(negedge clk);
      {md, fault, ol_on, ol_off, diag} = v[i];
      mode = md[1:0];
      repeat (5) @(negedge clk);
      i_spi_host_model.xfer(STAT, 16, rep);
      i_spi_host_model.xfer(STAT, 16, rep);
      fr(STAT, 16, e[i], "status flags");
    end
  endtask : t_status

  initial
  begin
    fail_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    uv = 1'b0;
    vdd_low = 1'b0;
    mode = 2'b11;
    in_pins = 2'b00;
    ol_on = 8'h00;
    ol_off = 8'h00;
    fault = 8'h00;
    diag = 8'h00;
    repeat (20) @(posedge clk);
    @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    t_reset;
    t_regs;
    t_bad;
    t_syntax;
    t_sticky;
    t_input;
    t_status;
    tally_and_finish;
  end

  initial
  begin
    #100us;
    fail_count++;
    $display("[FAIL] watchdog expected done seen hang");
    tally_and_finish;
  end
endmodule : relay_driver_spi_status_regs_test
